// ---- core/ubs_map.svh ----
`ifndef UBS_MAP_SVH
`define UBS_MAP_SVH

// =====================================================================
// Register map
`define UBS_ADDR_BASE      16'hDE00
`define UBS_ADDR_LAST      16'hDE3F
`define UBS_ADDR_RSVD      16'hDE2C
`define UBS_ADDR_FADDR     16'hDE00
`define UBS_ADDR_POWER     16'hDE01
`define UBS_ADDR_CFLAGS    16'hDE06
`define UBS_ADDR_CENABLES  16'hDE0B
`define UBS_ADDR_EPSEL     16'hDE0E
`define UBS_ADDR_IDX_LO    16'hDE10

// =====================================================================
// Field positions and reset values
`define UBS_FA_UPDATE      7
`define UBS_PW_ISO_WAIT    7
`define UBS_PW_RST         3
`define UBS_PW_RESUME      2
`define UBS_PW_SUSPEND     1
`define UBS_PW_SUSP_EN     0
`define UBS_EV_SOF         3
`define UBS_EV_RST         2
`define UBS_EV_RESUME      1
`define UBS_EV_SUSPEND     0
`define UBS_EN_RESET       4'h6
`define UBS_EN_ON_BUSRST   4'h6

// =====================================================================
// Line states as {dp, dm}
`define UBS_LINE_SE0       2'b00
`define UBS_LINE_IDLE      2'b10
`define UBS_LINE_K         2'b01

// =====================================================================
// Timing
`define UBS_CLK_PERIOD_NS  100
`define UBS_RST_SE0_NS     2500
`define UBS_RST_CYC        ((`UBS_RST_SE0_NS + `UBS_CLK_PERIOD_NS - 1) / `UBS_CLK_PERIOD_NS)
`define UBS_IDLE_TIME_NS   3000000
`define UBS_IDLE_CYC       (`UBS_IDLE_TIME_NS / `UBS_CLK_PERIOD_NS)
`define UBS_IDLE_W         16
`define UBS_SE0_W          5

`endif

// ---- core/ubs_pkg.sv ----
`default_nettype none
`include "ubs_map.svh"

package ubs_pkg;

   // ==================================================================
   // Bus state of the controller
   typedef enum logic [2:0] {
      UBS_ACTIVE    = 3'b001,
      UBS_SUSPENDED = 3'b010,
      UBS_BUSRESET  = 3'b100
   } ubs_mode_t;

   // ==================================================================
   // CPU data-space access, one cycle strobes
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } ubs_cpu_req_t;

   // Bus pin drive
   typedef struct packed {
      logic dp_o;
      logic dp_oe;
      logic dm_o;
      logic dm_oe;
   } ubs_pins_t;

   // Controls toward the endpoint bank
   typedef struct packed {
      logic [3:0] ep_select;
      logic       fifo_flush;
      logic       ep_cs_clear;
      logic       send_zero_len;
   } ubs_ep_ctrl_t;

   // ==================================================================
   // Whole state of the block
   typedef struct packed {
      ubs_mode_t                mode;
      logic [1:0]               sync1;
      logic [1:0]               sync2;
      logic [1:0]               sync3;
      logic [1:0]               line;
      logic [`UBS_SE0_W-1:0]    se0_cnt;
      logic                     in_reset;
      logic [`UBS_IDLE_W-1:0]   idle_cnt;
      logic [6:0]               addr;
      logic                     addr_upd;
      logic                     iso_wait_sof;
      logic                     resume;
      logic                     susp_stat;
      logic                     suspend_en;
      logic [3:0]               flags;
      logic [3:0]               enables;
      logic [3:0]               ep_index;
      logic                     iso_pending;
      logic [7:0]               rdata;
      logic                     irq_set;
      logic                     irq_req;
      logic                     wake;
      logic                     flush;
   } ubs_state_t;

endpackage

`default_nettype wire

// ---- core/ubs_bus_state.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ubs_map.svh"

module ubs_bus_state
   import ubs_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = `UBS_IDLE_CYC
)(
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire ubs_cpu_req_t cpu_req,
   output logic [7:0]        cpu_rdata,
   input  wire logic         dp_i,
   input  wire logic         dm_i,
   output ubs_pins_t         pins,
   input  wire logic         sof_seen,
   input  wire logic         in_packet_loaded,
   input  wire logic         addr_take,
   input  wire logic         global_usb_irq_enable,
   input  wire logic [7:0]   ep_rdata,
   output ubs_ep_ctrl_t      ep_ctrl,
   output logic              cpu_usb_irq_flag_set,
   output logic              usb_irq_req,
   output logic              system_wake
);

   localparam logic [`UBS_SE0_W-1:0]  RST_CYC  = `UBS_SE0_W'(`UBS_RST_CYC);
   localparam logic [`UBS_IDLE_W-1:0] IDLE_CYC = `UBS_IDLE_W'(IDLE_CYCLES);

   ubs_state_t s_r;
   ubs_state_t s_nxt;

   // =====================================================================
   // Decode helper
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   // =====================================================================
   // Combinational decode of this cycle's events
   logic se0;
   logic line_idle;
   logic rst_det;
   logic susp_det;
   logic resume_det;
   logic rd_flags;
   logic wr_addr;
   logic wr_power;
   logic in_space;
   logic in_index;
   logic [3:0] ev;

   assign se0        = (s_r.line == `UBS_LINE_SE0);
   assign line_idle  = (s_r.line == `UBS_LINE_IDLE);
   // Reset seen once SE0 has lasted the least reset time
   assign rst_det    = se0 && (s_r.se0_cnt == RST_CYC - 1'b1);
   assign susp_det   = s_r.suspend_en && (s_r.mode == UBS_ACTIVE)
                       && (s_r.idle_cnt == IDLE_CYC - 1'b1) && line_idle;
   // Any state other than J or SE0 counts as resume; SE0 in suspend is a reset instead
   assign resume_det = (s_r.mode == UBS_SUSPENDED) && !se0 && !line_idle;
   // Only the reserved-free part of the window is decoded
   assign in_space   = (cpu_req.addr >= `UBS_ADDR_BASE)
                       && (cpu_req.addr < `UBS_ADDR_RSVD);
   assign in_index   = in_space && (cpu_req.addr >= `UBS_ADDR_IDX_LO);
   assign rd_flags   = cpu_req.rd && hit(cpu_req.addr, `UBS_ADDR_CFLAGS);
   assign wr_addr    = cpu_req.wr && hit(cpu_req.addr, `UBS_ADDR_FADDR);
   assign wr_power   = cpu_req.wr && hit(cpu_req.addr, `UBS_ADDR_POWER);

   // Event vector in flag bit order
   always_comb begin
      ev                  = 4'h0;
      ev[`UBS_EV_SOF]     = sof_seen;
      ev[`UBS_EV_RST]     = rst_det;
      ev[`UBS_EV_RESUME]  = resume_det;
      ev[`UBS_EV_SUSPEND] = susp_det;
   end

   // =====================================================================
   // Next-state logic
   always_comb begin
      s_nxt       = s_r;
      s_nxt.flush = 1'b0;
      s_nxt.wake  = 1'b0;

      // Three-stage pin sampler; second and third must agree
      s_nxt.sync1 = {dp_i, dm_i};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      if (s_r.sync2 == s_r.sync3) begin
         s_nxt.line = s_r.sync3;
      end

      // SE0 duration counter, saturating one count past the detect point
      if (!se0) begin
         s_nxt.se0_cnt  = '0;
         s_nxt.in_reset = 1'b0;
      end else if (s_r.se0_cnt != RST_CYC) begin
         s_nxt.se0_cnt = s_r.se0_cnt + 1'b1;
      end
      if (rst_det) begin
         s_nxt.in_reset = 1'b1;
      end

      // Idle timer; any activity restarts it, barred suspend clears it
      if (!s_r.suspend_en || !line_idle || s_r.mode != UBS_ACTIVE) begin
         s_nxt.idle_cnt = '0;
      end else if (s_r.idle_cnt != IDLE_CYC) begin
         s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
      end

      // Address and update bit; update drops once the SIE takes it
      if (addr_take) begin
         s_nxt.addr_upd = 1'b0;
      end
      if (wr_addr) begin
         s_nxt.addr     = cpu_req.wdata[6:0];
         s_nxt.addr_upd = 1'b1;
      end

      // Power/control writes
      if (wr_power) begin
         s_nxt.iso_wait_sof = cpu_req.wdata[`UBS_PW_ISO_WAIT];
         s_nxt.resume       = cpu_req.wdata[`UBS_PW_RESUME];
         s_nxt.suspend_en   = cpu_req.wdata[`UBS_PW_SUSP_EN];
      end
      if (cpu_req.wr && hit(cpu_req.addr, `UBS_ADDR_CENABLES)) begin
         s_nxt.enables = cpu_req.wdata[3:0];
      end
      if (cpu_req.wr && hit(cpu_req.addr, `UBS_ADDR_EPSEL)) begin
         s_nxt.ep_index = cpu_req.wdata[3:0];
      end

      // Iso hold-off: loaded packet waits for the next SOF
      if (sof_seen) begin
         s_nxt.iso_pending = 1'b0;
      end else if (in_packet_loaded) begin
         s_nxt.iso_pending = 1'b1;
      end

      // Event flags: read clears, a new event in the same cycle wins
      if (rd_flags) begin
         s_nxt.flags     = 4'h0;
         s_nxt.susp_stat = 1'b0;
      end
      s_nxt.flags = s_nxt.flags | ev;

      // Mode transitions
      case (s_r.mode)
         UBS_ACTIVE: begin
            if (susp_det) begin
               s_nxt.mode      = UBS_SUSPENDED;
               s_nxt.susp_stat = 1'b1;
            end
         end
         UBS_SUSPENDED: begin
            if (resume_det) begin
               s_nxt.mode = UBS_ACTIVE;
               s_nxt.wake = s_r.enables[`UBS_EV_RESUME];
            end
         end
         UBS_BUSRESET: begin
            if (!se0) begin
               s_nxt.mode = UBS_ACTIVE;
            end
         end
         default: begin
            s_nxt.mode = UBS_ACTIVE;
         end
      endcase

      // Resume write beats a suspend entry landing in the same cycle
      if (wr_power && cpu_req.wdata[`UBS_PW_RESUME]) begin
         s_nxt.susp_stat = 1'b0;
         s_nxt.mode      = UBS_ACTIVE;
      end

      // Bus reset overrides the mode, address and update bit, index, enables and iso hold-off set above
      if (rst_det) begin
         if (s_r.mode == UBS_SUSPENDED) begin
            s_nxt.wake = s_r.enables[`UBS_EV_RESUME];
         end
         s_nxt.mode     = UBS_BUSRESET;
         s_nxt.addr     = 7'h00;
         s_nxt.addr_upd = 1'b0;
         s_nxt.ep_index = 4'h0;
         s_nxt.flush    = 1'b1;
         s_nxt.enables  = `UBS_EN_ON_BUSRST;
         s_nxt.iso_pending = 1'b0;
      end

      // CPU flag pulse and level request from enabled events
      s_nxt.irq_set = |(ev & s_nxt.enables);
      s_nxt.irq_req = global_usb_irq_enable && |(s_nxt.flags & s_nxt.enables);

      // Registered read data; reserved and unmapped read as zero
      s_nxt.rdata = 8'h00;
      if (cpu_req.rd && in_space) begin
         if (in_index) begin
            s_nxt.rdata = ep_rdata;
         end else begin
            case (cpu_req.addr)
               `UBS_ADDR_FADDR: begin
                  s_nxt.rdata = {s_r.addr_upd, s_r.addr};
               end
               `UBS_ADDR_POWER: begin
                  s_nxt.rdata[`UBS_PW_ISO_WAIT] = s_r.iso_wait_sof;
                  s_nxt.rdata[`UBS_PW_RST]      = s_r.in_reset;
                  s_nxt.rdata[`UBS_PW_RESUME]   = s_r.resume;
                  s_nxt.rdata[`UBS_PW_SUSPEND]  = s_r.susp_stat;
                  s_nxt.rdata[`UBS_PW_SUSP_EN]  = s_r.suspend_en;
               end
               `UBS_ADDR_CFLAGS: begin
                  s_nxt.rdata[3:0] = s_r.flags;
               end
               `UBS_ADDR_CENABLES: begin
                  s_nxt.rdata[3:0] = s_r.enables;
               end
               `UBS_ADDR_EPSEL: begin
                  s_nxt.rdata[3:0] = s_r.ep_index;
               end
               default: begin
                  s_nxt.rdata = 8'h00;
               end
            endcase
         end
      end
   end

   // =====================================================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_r         <= '0;
         s_r.mode    <= UBS_ACTIVE;
         s_r.line    <= `UBS_LINE_IDLE;
         s_r.sync1   <= `UBS_LINE_IDLE;
         s_r.sync2   <= `UBS_LINE_IDLE;
         s_r.sync3   <= `UBS_LINE_IDLE;
         s_r.enables <= `UBS_EN_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // =====================================================================
   // Outputs from the state register, send_zero_len through one AND; dp_o and dm_o are constants
   // Resume drives K upstream; software owns the 1..15 ms duration
   assign pins.dp_o  = 1'b0;
   assign pins.dm_o  = 1'b1;
   assign pins.dp_oe = s_r.resume;
   assign pins.dm_oe = s_r.resume;
   assign ep_ctrl.ep_select     = s_r.ep_index;
   assign ep_ctrl.fifo_flush    = s_r.flush;
   assign ep_ctrl.ep_cs_clear   = s_r.flush;
   assign ep_ctrl.send_zero_len = s_r.iso_wait_sof && s_r.iso_pending;
   assign cpu_rdata             = s_r.rdata;
   assign cpu_usb_irq_flag_set  = s_r.irq_set;
   assign usb_irq_req           = s_r.irq_req;
   assign system_wake           = s_r.wake;

   // =====================================================================
   // Checks
   sequence q_rst_det;
      se0 && (s_r.se0_cnt == RST_CYC - 1'b1);
   endsequence

   sequence q_rd_flags_quiet;
      rd_flags && (ev == 4'h0);
   endsequence

   a_rst_sets_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
      q_rst_det |=> s_r.flags[`UBS_EV_RST] && s_r.in_reset)
      else $error("bus reset did not set reset flag");

   a_rst_clears_regs: assert property (@(posedge clk_sys) disable iff (!resetn)
      q_rst_det |=> (s_r.addr == 7'h00) && (s_r.ep_index == 4'h0) && ep_ctrl.fifo_flush)
      else $error("bus reset left address or index");

   a_rst_enables: assert property (@(posedge clk_sys) disable iff (!resetn)
      q_rst_det |=> s_r.enables == `UBS_EN_ON_BUSRST)
      else $error("bus reset enables wrong");

   a_irq_from_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ev[`UBS_EV_RST] && !rd_flags) ##1 1'b1 |-> cpu_usb_irq_flag_set
         && (usb_irq_req == global_usb_irq_enable || !$stable(global_usb_irq_enable)))
      else $error("reset event did not raise irq flag");

   a_suspend_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
      (susp_det && !rst_det && !(wr_power && cpu_req.wdata[`UBS_PW_RESUME]))
         |=> s_r.mode == UBS_SUSPENDED && s_r.flags[`UBS_EV_SUSPEND]
         && (s_r.susp_stat || $past(rd_flags)))
      else $error("suspend not entered after idle");

   a_idle_held: assert property (@(posedge clk_sys) disable iff (!resetn)
      !s_r.suspend_en [*2] |-> s_r.idle_cnt == '0)
      else $error("idle timer ran while suspend barred");

   a_resume_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
      resume_det && !wr_power |=> s_r.flags[`UBS_EV_RESUME] && s_r.mode == UBS_ACTIVE)
      else $error("resume signalling not flagged");

   a_rst_in_susp: assert property (@(posedge clk_sys) disable iff (!resetn)
      ((s_r.mode == UBS_SUSPENDED) ##0 q_rst_det)
         |=> s_r.flags[`UBS_EV_RST] && (system_wake == $past(s_r.enables[`UBS_EV_RESUME])))
      else $error("reset in suspend mishandled");

   a_resume_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_power && cpu_req.wdata[`UBS_PW_RESUME]) |=> pins.dp_oe && !s_r.susp_stat ##0
         (!pins.dp_o && pins.dm_o))
      else $error("resume not driven");

   a_flags_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
      q_rd_flags_quiet |=> s_r.flags == 4'h0 && !s_r.susp_stat)
      else $error("flags not cleared by read");

   a_addr_update: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_addr && !rst_det) |=> s_r.addr_upd && s_r.addr == $past(cpu_req.wdata[6:0]))
      else $error("address write not pending");

   a_iso_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
      (in_packet_loaded && !sof_seen && !rst_det && s_r.iso_wait_sof && !wr_power)
         |=> ep_ctrl.send_zero_len)
      else $error("iso wait did not send zero length");

   a_cs_clear_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
      q_rst_det |=> ep_ctrl.ep_cs_clear ##1 !ep_ctrl.ep_cs_clear)
      else $error("endpoint status clear not a single pulse");

   a_susp_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
      (susp_det && s_nxt.enables[`UBS_EV_SUSPEND]) |=> cpu_usb_irq_flag_set)
      else $error("suspend event did not raise irq flag");

   a_rst_status_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      (s_r.in_reset && se0) |=> s_r.in_reset)
      else $error("reset status dropped during SE0");

   a_rst_status_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
      !se0 |=> !s_r.in_reset)
      else $error("reset status stayed after SE0 ended");

   a_susp_set_only: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(s_r.susp_stat) |-> $past(susp_det))
      else $error("suspend status set without suspend entry");

   a_rsvd_reads_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
      (cpu_req.rd && (cpu_req.addr >= `UBS_ADDR_RSVD)) |=> cpu_rdata == 8'h00)
      else $error("reserved or outside address read nonzero");

   a_ep_select: assert property (@(posedge clk_sys) disable iff (!resetn)
      (cpu_req.wr && hit(cpu_req.addr, `UBS_ADDR_EPSEL) && !rst_det)
         |=> ep_ctrl.ep_select == $past(cpu_req.wdata[3:0]))
      else $error("endpoint select not written");

endmodule

`default_nettype wire

// ---- tb/ubs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ubs_map.svh"

// =====================================================================
// Upstream host or hub: drives line states, sees device drive on the wire
module ubs_host_model
   import ubs_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire ubs_pins_t pins,
   output logic           dp_i,
   output logic           dm_i
);
   logic [1:0] host_line;

   // Full-speed bus rests in J through the pull-up
   initial host_line = `UBS_LINE_IDLE;

   // Device drive wins on each line while its enable is high
   assign dp_i = pins.dp_oe ? pins.dp_o : host_line[1];
   assign dm_i = pins.dm_oe ? pins.dm_o : host_line[0];

   // Hold one line state for a number of cycles, changed just after an edge
   task automatic drive(input logic [1:0] st, input int cycles);
      @(posedge clk_sys);
      #1 host_line = st;
      repeat (cycles) @(posedge clk_sys);
      // Return off the edge so callers look at settled outputs
      #1;
   endtask
endmodule
`default_nettype wire

// ---- tb/usb_bus_state_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ubs_map.svh"

module usb_bus_state_control_tb_top
   import ubs_pkg::*;
;
   localparam int IDLE = 40;
   logic         clk_sys;
   logic         resetn;
   ubs_cpu_req_t cpu_req;
   logic [7:0]   cpu_rdata;
   logic [7:0]   ep_rdata;
   logic         dp_i;
   logic         dm_i;
   ubs_pins_t    pins;
   logic         sof_seen;
   logic         in_packet_loaded;
   logic         addr_take;
   logic         global_usb_irq_enable;
   ubs_ep_ctrl_t ep_ctrl;
   logic         irq_set;
   logic         irq_req;
   logic         wake;
   int           errors;
   int           checks_done;
   int           flush_cnt;
   int           wake_cnt;
   int           irqset_cnt;
   int           seed;
   logic [7:0]   exp_q[$];
   logic         rd_pend;
   logic [7:0]   v;

   // =====================================================================
   // Design and far side
   ubs_bus_state #(.IDLE_CYCLES(IDLE)) dut_u (
      .clk_sys(clk_sys), .resetn(resetn), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
      .dp_i(dp_i), .dm_i(dm_i), .pins(pins), .sof_seen(sof_seen),
      .in_packet_loaded(in_packet_loaded), .addr_take(addr_take),
      .global_usb_irq_enable(global_usb_irq_enable), .ep_rdata(ep_rdata),
      .ep_ctrl(ep_ctrl), .cpu_usb_irq_flag_set(irq_set), .usb_irq_req(irq_req),
      .system_wake(wake));
   ubs_host_model host_u (.clk_sys(clk_sys), .pins(pins), .dp_i(dp_i), .dm_i(dm_i));

   // =====================================================================
   // Clock and helpers
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1 cpu_req.addr = a;
      cpu_req.wdata = d;
      cpu_req.wr = 1'b1;
      @(posedge clk_sys);
      #1 cpu_req.wr = 1'b0;
   endtask

   // The expected byte is noted when the read is launched
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      #1 cpu_req.addr = a;
      cpu_req.rd = 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      #1 cpu_req.rd = 1'b0;
   endtask

   task automatic pulse(ref logic s);
      @(posedge clk_sys);
      #1 s = 1'b1;
      @(posedge clk_sys);
      #1 s = 1'b0;
   endtask

   // Read data stands one cycle after the strobe; pulses are counted here
   always @(posedge clk_sys) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) chk(cpu_rdata, 8'h00);
         else chk(cpu_rdata, exp_q.pop_front());
      end
      rd_pend <= cpu_req.rd;
      // Flush and status clear must pulse together to count
      if (ep_ctrl.fifo_flush === 1'b1 && ep_ctrl.ep_cs_clear === 1'b1) flush_cnt++;
      if (irq_set === 1'b1) irqset_cnt++;
      if (wake === 1'b1) wake_cnt++;
   end

   // Hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #2000000;
      errors++;
      give_verdict();
   end

   // =====================================================================
   // Main sequence
   initial begin
      seed = 32'h6c56bf5f;
      cpu_req = '0;
      {sof_seen, in_packet_loaded, addr_take, global_usb_irq_enable} = 4'h0;
      {errors, checks_done, flush_cnt, wake_cnt, irqset_cnt} = '0;
      rd_pend = 1'b0;
      ep_rdata = 8'h00;
      resetn = 1'b0;
      repeat (10) @(posedge clk_sys);
      #1 resetn = 1'b1;
      rd(`UBS_ADDR_FADDR, 8'h00);
      rd(`UBS_ADDR_POWER, 8'h00);
      rd(`UBS_ADDR_CENABLES, 8'h06);
      // Address write marks the update pending until it takes effect
      v = 8'($random(seed)) & 8'h7F;
      wr(`UBS_ADDR_FADDR, v);
      rd(`UBS_ADDR_FADDR, v | 8'h80);
      pulse(addr_take);
      rd(`UBS_ADDR_FADDR, v);
      wr(`UBS_ADDR_EPSEL, 8'h05);
      wr(`UBS_ADDR_CENABLES, 8'h0F);
      chk(8'(ep_ctrl.ep_select), 8'h05);
      global_usb_irq_enable = 1'b1;
      // Bus reset, status bit read while the line still holds SE0
      host_u.drive(`UBS_LINE_SE0, 35);
      rd(`UBS_ADDR_POWER, 8'h08);
      host_u.drive(`UBS_LINE_IDLE, 5);
      chk(8'(irq_req), 8'h01);
      chk(8'(irqset_cnt), 8'h01);
      chk(8'(flush_cnt), 8'h01);
      rd(`UBS_ADDR_CFLAGS, 8'h04);
      rd(`UBS_ADDR_CFLAGS, 8'h00);
      rd(`UBS_ADDR_FADDR, 8'h00);
      rd(`UBS_ADDR_CENABLES, 8'h06);
      chk(8'(ep_ctrl.ep_select), 8'h00);
      chk(8'(irq_req), 8'h00);
      // Indexed bank, reserved space and outside the window
      ep_rdata = 8'($random(seed));
      rd(`UBS_ADDR_IDX_LO, ep_rdata);
      rd(`UBS_ADDR_RSVD, 8'h00);
      rd(16'hDE40, 8'h00);
      // Long idle without permit must not suspend
      host_u.drive(`UBS_LINE_IDLE, IDLE + 20);
      rd(`UBS_ADDR_POWER, 8'h00);
      wr(`UBS_ADDR_CENABLES, 8'h07);
      wr(`UBS_ADDR_POWER, 8'h01);
      host_u.drive(`UBS_LINE_IDLE, IDLE + 20);
      rd(`UBS_ADDR_POWER, 8'h03);
      chk(8'(irqset_cnt), 8'h02);
      // Host resume by K while suspended
      host_u.drive(`UBS_LINE_K, 10);
      host_u.drive(`UBS_LINE_IDLE, 2);
      chk(8'(wake_cnt), 8'h01);
      // Settle gap after wakeup before touching registers again
      repeat (4) @(posedge clk_sys);
      rd(`UBS_ADDR_CFLAGS, 8'h03);
      rd(`UBS_ADDR_POWER, 8'h01);
      // Bus reset while suspended wakes and flags reset beside suspend, not resume
      host_u.drive(`UBS_LINE_IDLE, IDLE + 20);
      host_u.drive(`UBS_LINE_SE0, 35);
      host_u.drive(`UBS_LINE_IDLE, 5);
      chk(8'(wake_cnt), 8'h02);
      chk(8'(flush_cnt), 8'h02);
      rd(`UBS_ADDR_CFLAGS, 8'h05);
      // Remote wakeup from suspend drives K and clears suspend status
      host_u.drive(`UBS_LINE_IDLE, IDLE + 20);
      rd(`UBS_ADDR_POWER, 8'h03);
      wr(`UBS_ADDR_POWER, 8'h05);
      rd(`UBS_ADDR_POWER, 8'h05);
      chk(8'({pins.dp_o, pins.dp_oe, pins.dm_o, pins.dm_oe}), 8'h07);
      // Hold kept short; milliseconds would dominate the run
      repeat (10) @(posedge clk_sys);
      wr(`UBS_ADDR_POWER, 8'h00);
      rd(`UBS_ADDR_CFLAGS, 8'h01);
      // Iso wait sends empty packets until the next SOF
      wr(`UBS_ADDR_POWER, 8'h80);
      pulse(in_packet_loaded);
      chk(8'(ep_ctrl.send_zero_len), 8'h01);
      pulse(sof_seen);
      chk(8'(ep_ctrl.send_zero_len), 8'h00);
      rd(`UBS_ADDR_CFLAGS, 8'h08);
      repeat (3) @(posedge clk_sys);
      give_verdict();
   end
endmodule
`default_nettype wire
